// >>> hw/cut_length_virtual_master_setup.sv
// cut length selection, deferred parameters, line scaling, virtual master
//
// What this block does
// (RULE_01) length, circumference and pulse writes wait pending until next cutting pulse; speed, ramp and ctrl writes act at once
// (RULE_02) profile computed in sync zone after cut
// (RULE_03) select low cuts normal length 1..999999
// (RULE_04) test length when select high or latched
// (RULE_05) speed setpoint 0..9999999, clamped to max
// (RULE_06) internal speed step is max/10000
// (RULE_07) circumference setting 1..99999 length units
// (RULE_08) pulses per rev count x1/x2/x4 edges
// (RULE_09) ramp time 0..999 s, standstill to max
// (RULE_10) linear ramp; zero ramp steps immediately
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cutlen_defines.svh"
module cut_length_virtual_master_setup
	import cutlen_pkg::*;
#(
	parameter int UNIT_CYCLES = `VM_UNIT_CYCLES
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// control inputs and line encoder
	input wire logic i_cut_pulse,
	input wire logic i_test_sel,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	// profile results
	output logic [39:0] o_cut_edges,
	output logic o_test_cut,
	output logic o_profile_busy,
	output logic [31:0] o_line_edges,
	// virtual master
	output logic [13:0] o_vm_units,
	output logic o_vm_moving
);

	if (UNIT_CYCLES < 1) begin : g_bad_param
		$error("cut_length_virtual_master_setup: UNIT_CYCLES < 1");
	end

	// -------------------------------------------------------------
	// range limiting of written values
	// -------------------------------------------------------------
	function automatic logic [31:0] limit(input logic [31:0] v,
			input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	function automatic edge_mult_e mult_dec(input logic [1:0] code);
		edge_mult_e m;
		unique case (code)
			2'h1: m = EDGE_X2;
			2'h2: m = EDGE_X4;
			default: m = EDGE_X1;
		endcase
		return m;
	endfunction

	function automatic logic [1:0] mult_enc(input edge_mult_e m);
		logic [1:0] c;
		unique case (m)
			EDGE_X2: c = 2'h1;
			EDGE_X4: c = 2'h2;
			default: c = 2'h0;
		endcase
		return c;
	endfunction

	top_state_s s_q;
	top_state_s s_d;

	// -------------------------------------------------------------
	// divider and ramp hookups
	// -------------------------------------------------------------
	logic prof_start;
	logic [39:0] prof_num;
	logic [39:0] prof_den;
	logic prof_done;
	logic [39:0] prof_quot;
	logic spd_start;
	logic spd_busy;
	logic spd_done;
	logic [39:0] spd_num;
	logic [39:0] spd_quot;
	logic [23:0] spd_eff;
	logic [13:0] vm_speed;
	logic vm_moving;

	// -------------------------------------------------------------
	// dividers and ramp
	// -------------------------------------------------------------
	assign prof_start = (s_q.prof == PRF_START);
	// edges per cut = length * pulses per rev / circumference
	assign prof_num = 40'(s_q.len_a) * 40'(s_q.ppr_a); // RULE_08
	assign prof_den = 40'(s_q.circ_a); // RULE_07

	serial_divider #(
		.W(40)
	) u_prof_div (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_start(prof_start),
		.i_num(prof_num),
		.i_den(prof_den),
		.o_busy(),
		.o_done(prof_done),
		.o_quot(prof_quot)
	);

	// effective setpoint clamped to max line speed
	assign spd_eff = (s_q.speed_sp > s_q.max_speed) ?
		s_q.max_speed : s_q.speed_sp; // RULE_05
	assign spd_num = 40'(spd_eff) * 40'(`VM_RESOLUTION); // RULE_06
	assign spd_start = s_q.spd_req && !spd_busy;

	serial_divider #(
		.W(40)
	) u_spd_div (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_start(spd_start),
		.i_num(spd_num),
		.i_den(40'(s_q.max_speed)),
		.o_busy(spd_busy),
		.o_done(spd_done),
		.o_quot(spd_quot)
	);

	speed_ramp #(
		.RES(`VM_RESOLUTION),
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_ramp (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_target(s_q.vm_target),
		.i_ramp_s(s_q.ramp_s),
		.o_speed(vm_speed),
		.o_moving(vm_moving)
	);

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		logic cut;
		logic a_edge;
		logic b_edge;
		logic step;
		logic up;
		logic [31:0] wv;
		cut = i_cut_pulse && !s_q.cut_prev;
		a_edge = i_enc_a ^ s_q.a_prev;
		b_edge = i_enc_b ^ s_q.b_prev;
		step = 1'b0;
		up = 1'b0;
		wv = i_wdata;
		s_d = s_q;
		s_d.cut_prev = i_cut_pulse;
		s_d.a_prev = i_enc_a;
		s_d.b_prev = i_enc_b;

		// -----------------------------------------------------
		// encoder edges after multiplication
		// -----------------------------------------------------
		unique case (s_q.mult)
			EDGE_X1: begin
				step = a_edge && i_enc_a; // RULE_08
				up = !i_enc_b;
			end
			EDGE_X2: begin
				step = a_edge; // RULE_08
				up = i_enc_a ^ i_enc_b;
			end
			EDGE_X4: begin
				step = a_edge || b_edge; // RULE_08
				up = a_edge ? (i_enc_a ^ i_enc_b) :
					!(i_enc_a ^ i_enc_b);
			end
			default: begin
				step = 1'b0;
				up = 1'b0;
			end
		endcase
		if (step) begin
			s_d.line_edges = up ? s_q.line_edges + 32'h1 :
				s_q.line_edges - 32'h1;
		end

		// -----------------------------------------------------
		// test request held until the next cut
		// -----------------------------------------------------
		if (i_test_sel) begin
			s_d.test_req = 1'b1; // RULE_04
		end

		// -----------------------------------------------------
		// length, circumference and pulse writes go to the pending set; speed, ramp and ctrl writes act at once
		// -----------------------------------------------------
		if (i_wr) begin
			unique case (i_addr)
				`ADR_CUT_LEN: s_d.cut_len_p =
					20'(limit(wv, `LEN_MIN, `LEN_MAX)); // RULE_01
				`ADR_TEST_LEN: s_d.test_len_p =
					20'(limit(wv, `LEN_MIN, `LEN_MAX)); // RULE_01
				`ADR_CIRC: s_d.circ_p =
					17'(limit(wv, `LEN_MIN, `CIRC_MAX)); // RULE_07
				`ADR_PPR: s_d.ppr_p =
					20'(limit(wv, `LEN_MIN, `PPR_MAX)); // RULE_08
				`ADR_SPEED_SP: begin
					s_d.speed_sp = 24'(limit(wv, 32'h0, `SPEED_MAX)); // RULE_05
					s_d.spd_req = 1'b1;
				end
				`ADR_MAX_SPEED: begin
					s_d.max_speed = 24'(limit(wv, 32'h0, `SPEED_MAX));
					s_d.spd_req = 1'b1;
				end
				`ADR_RAMP: s_d.ramp_s =
					10'(limit(wv, 32'h0, `RAMP_MAX)); // RULE_09
				`ADR_CTRL: s_d.mult = mult_dec(wv[`CTRL_MULT_LSB +: 2]);
				default: ;
			endcase
		end

		// -----------------------------------------------------
		// scaled speed target, new request wins over the clear
		// -----------------------------------------------------
		if (spd_start && !(i_wr && (i_addr == `ADR_SPEED_SP ||
				i_addr == `ADR_MAX_SPEED))) begin
			s_d.spd_req = 1'b0;
		end
		if (spd_done) begin
			s_d.vm_target = (s_q.max_speed == 24'h0) ? 14'h0 :
				14'(spd_quot); // RULE_06
		end

		// -----------------------------------------------------
		// profile sequence
		// -----------------------------------------------------
		unique case (s_q.prof)
			PRF_IDLE: ;
			PRF_START: s_d.prof = PRF_WAIT;
			PRF_WAIT: begin
				if (prof_done) begin
					s_d.cut_edges = prof_quot; // RULE_02
					s_d.busy = 1'b0;
					s_d.prof = PRF_IDLE;
				end
			end
			default: s_d.prof = PRF_IDLE;
		endcase

		// -----------------------------------------------------
		// cutting pulse: pending values become active
		// -----------------------------------------------------
		if (cut) begin
			s_d.test_a = s_q.test_req || i_test_sel; // RULE_04
			s_d.len_a = (s_q.test_req || i_test_sel) ?
				s_d.test_len_p : s_d.cut_len_p; // RULE_03
			s_d.circ_a = s_d.circ_p; // RULE_01
			s_d.ppr_a = s_d.ppr_p; // RULE_01
			s_d.test_req = i_test_sel;
			s_d.line_edges = 32'h0;
			s_d.busy = 1'b1;
			s_d.prof = PRF_START; // RULE_02
		end

		// -----------------------------------------------------
		// read data stands for one cycle only
		// -----------------------------------------------------
		s_d.rdata = 32'h0;
		if (i_rd) begin
			unique case (i_addr)
				`ADR_CUT_LEN: s_d.rdata = 32'(s_q.cut_len_p);
				`ADR_TEST_LEN: s_d.rdata = 32'(s_q.test_len_p);
				`ADR_SPEED_SP: s_d.rdata = 32'(s_q.speed_sp);
				`ADR_CIRC: s_d.rdata = 32'(s_q.circ_p);
				`ADR_PPR: s_d.rdata = 32'(s_q.ppr_p);
				`ADR_RAMP: s_d.rdata = 32'(s_q.ramp_s);
				`ADR_MAX_SPEED: s_d.rdata = 32'(s_q.max_speed);
				`ADR_CTRL: s_d.rdata = 32'(mult_enc(s_q.mult));
				`ADR_STATUS: begin
					s_d.rdata[`STAT_TEST_BIT] = s_q.test_a;
					s_d.rdata[`STAT_BUSY_BIT] = s_q.busy;
					s_d.rdata[`STAT_MOVING_BIT] = vm_moving;
				end
				`ADR_CUT_EDGES: s_d.rdata = s_q.cut_edges[31:0];
				`ADR_VM_UNITS: s_d.rdata = 32'(vm_speed);
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.cut_len_p <= `RST_LEN;
			s_q.test_len_p <= `RST_LEN;
			s_q.circ_p <= `RST_CIRC;
			s_q.ppr_p <= `RST_PPR;
			s_q.len_a <= `RST_LEN;
			s_q.circ_a <= `RST_CIRC;
			s_q.ppr_a <= `RST_PPR;
			s_q.speed_sp <= `RST_SPEED;
			s_q.max_speed <= `RST_MAX_SPEED;
			s_q.ramp_s <= `RST_RAMP;
			s_q.mult <= EDGE_X1;
			s_q.prof <= PRF_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign o_rdata = s_q.rdata;
	assign o_cut_edges = s_q.cut_edges;
	assign o_test_cut = s_q.test_a;
	assign o_profile_busy = s_q.busy;
	assign o_line_edges = s_q.line_edges;
	assign o_vm_units = vm_speed;
	assign o_vm_moving = vm_moving;

endmodule

// >>> hw/cutlen_defines.svh
// constants: register offsets, field positions, reset values, timing
`ifndef CUTLEN_DEFINES_SVH
`define CUTLEN_DEFINES_SVH

// -----------------------------------------------------------------
// register indexes on the plain port
// -----------------------------------------------------------------
`define ADR_CUT_LEN 4'h0
`define ADR_TEST_LEN 4'h1
`define ADR_SPEED_SP 4'h2
`define ADR_CIRC 4'h3
`define ADR_PPR 4'h4
`define ADR_RAMP 4'h5
`define ADR_MAX_SPEED 4'h6
`define ADR_CTRL 4'h7
`define ADR_STATUS 4'h8
`define ADR_CUT_EDGES 4'h9
`define ADR_VM_UNITS 4'hA

// -----------------------------------------------------------------
// fields, ranges and reset values
// -----------------------------------------------------------------
`define CTRL_MULT_LSB 0
`define STAT_TEST_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_MOVING_BIT 2
`define LEN_MIN 32'h0000_0001
`define LEN_MAX 32'h000F_423F
`define SPEED_MAX 32'h0098_967F
`define CIRC_MAX 32'h0001_869F
`define PPR_MAX 32'h000F_423F
`define RAMP_MAX 32'h0000_03E7
`define RST_LEN 20'h003E8
`define RST_CIRC 17'h003E8
`define RST_PPR 20'h01000
`define RST_SPEED 24'h000000
`define RST_MAX_SPEED 24'h0F4240
`define RST_RAMP 10'h000

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_HZ 100000000
`define VM_RESOLUTION 10000
`define VM_UNIT_CYCLES (`CLK_HZ / `VM_RESOLUTION)

`endif

// >>> hw/cutlen_pkg.sv
// types shared by the cut length and virtual master logic
package cutlen_pkg;

	typedef enum logic [2:0] {
		EDGE_X1 = 3'b001,
		EDGE_X2 = 3'b010,
		EDGE_X4 = 3'b100
	} edge_mult_e;

	typedef enum logic [2:0] {
		PRF_IDLE = 3'b001,
		PRF_START = 3'b010,
		PRF_WAIT = 3'b100
	} prof_e;

	typedef struct packed {
		logic [19:0] cut_len_p;
		logic [19:0] test_len_p;
		logic [16:0] circ_p;
		logic [19:0] ppr_p;
		logic [19:0] len_a;
		logic [16:0] circ_a;
		logic [19:0] ppr_a;
		logic test_a;
		logic [23:0] speed_sp;
		logic [23:0] max_speed;
		logic [9:0] ramp_s;
		edge_mult_e mult;
		logic test_req;
		logic cut_prev;
		logic a_prev;
		logic b_prev;
		logic [31:0] line_edges;
		prof_e prof;
		logic busy;
		logic [39:0] cut_edges;
		logic spd_req;
		logic [13:0] vm_target;
		logic [31:0] rdata;
	} top_state_s;

endpackage

// >>> hw/serial_divider.sv
// restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module serial_divider #(
	parameter int W = 40
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// request
	input wire logic i_start,
	input wire logic [W-1:0] i_num,
	input wire logic [W-1:0] i_den,
	// result
	output logic o_busy,
	output logic o_done,
	output logic [W-1:0] o_quot
);

	localparam int CW = $clog2(W + 1);

	if (W < 2) begin : g_bad_width
		$error("serial_divider: W must be at least 2");
	end

	typedef struct packed {
		logic busy;
		logic done;
		logic [CW-1:0] cnt;
		logic [W:0] rem;
		logic [W-1:0] quo;
		logic [W-1:0] den;
	} div_s;

	div_s s_q;
	div_s s_d;

	always_comb begin
		logic [W:0] sh;
		sh = '0;
		s_d = s_q;
		s_d.done = 1'b0;
		if (i_start) begin
			s_d.busy = 1'b1;
			s_d.quo = i_num;
			s_d.rem = '0;
			s_d.den = i_den;
			s_d.cnt = CW'(W);
		end else if (s_q.busy) begin
			sh = {s_q.rem[W-1:0], s_q.quo[W-1]};
			if (s_q.den != '0 && sh >= {1'b0, s_q.den}) begin
				s_d.rem = sh - {1'b0, s_q.den};
				s_d.quo = {s_q.quo[W-2:0], 1'b1};
			end else begin
				s_d.rem = sh;
				s_d.quo = {s_q.quo[W-2:0], 1'b0};
			end
			s_d.cnt = s_q.cnt - CW'(1);
			if (s_q.cnt == CW'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_busy = s_q.busy;
	assign o_done = s_q.done;
	assign o_quot = s_q.quo;

endmodule

// >>> hw/speed_ramp.sv
// linear ramp of the virtual master speed, in 1/10000 of max speed
`timescale 1ns/1ps
module speed_ramp #(
	parameter int RES = 10000,
	parameter int UNIT_CYCLES = 10000
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// settings
	input wire logic [13:0] i_target,
	input wire logic [9:0] i_ramp_s,
	// speed
	output logic [13:0] o_speed,
	output logic o_moving
);

	if (RES < 1 || RES > 16383 || UNIT_CYCLES < 1) begin : g_bad_param
		$error("speed_ramp: resolution or unit cycles out of range");
	end

	typedef struct packed {
		logic [33:0] cnt;
		logic [13:0] speed;
		logic moving;
	} ramp_s_s;

	ramp_s_s s_q;
	ramp_s_s s_d;

	always_comb begin
		logic [33:0] period;
		period = 34'(i_ramp_s) * 34'(UNIT_CYCLES);
		s_d = s_q;
		if (i_ramp_s == 10'h000) begin
			s_d.speed = i_target; // RULE_10
			s_d.cnt = '0;
		end else if (s_q.speed == i_target) begin
			s_d.cnt = '0;
		end else if (s_q.cnt + 34'h1 >= period) begin
			s_d.cnt = '0;
			// one unit per step: full range over ramp time
			if (s_q.speed < i_target) begin
				s_d.speed = s_q.speed + 14'h1; // RULE_09
			end else begin
				s_d.speed = s_q.speed - 14'h1; // RULE_09
			end
		end else begin
			s_d.cnt = s_q.cnt + 34'h1; // RULE_10
		end
		s_d.moving = (s_d.speed != 14'h0);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_speed = s_q.speed;
	assign o_moving = s_q.moving;

endmodule

// >>> test/cutlen_sva.sv
// assertion checker for the cut length and virtual master block
`timescale 1ns/1ps
module cutlen_sva (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// watched ports
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_cut_pulse,
	input wire logic i_test_sel,
	input wire logic [39:0] o_cut_edges,
	input wire logic o_test_cut,
	input wire logic o_profile_busy,
	input wire logic [31:0] o_line_edges,
	input wire logic [13:0] o_vm_units,
	input wire logic o_vm_moving
);
	logic prev_q;
	logic cut_q;
	logic tq_q;
	wire cut_now = i_cut_pulse && !prev_q;
	// test request since the previous cut
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			prev_q <= 1'b0;
			cut_q <= 1'b0;
			tq_q <= 1'b0;
		end else begin
			prev_q <= i_cut_pulse;
			cut_q <= cut_now;
			tq_q <= i_test_sel || (tq_q && !cut_now);
		end
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_cut;
		cut_now;
	endsequence
	sequence s_cut_test;
		s_cut ##0 (i_test_sel || tq_q);
	endsequence
	sequence s_cut_norm;
		s_cut ##0 !(i_test_sel || tq_q);
	endsequence
	chk_cut_busy: assert property (s_cut |=> o_profile_busy && o_line_edges == 0)
		else $error("no busy or count clear after cut");
	chk_busy_bound: assert property (o_profile_busy |-> ##[0:43] !o_profile_busy)
		else $error("profile busy too long");
	chk_result_hold: assert property ($changed(o_cut_edges) |-> $fell(o_profile_busy))
		else $error("cut edges changed outside profile load");
	chk_test_pick: assert property (s_cut_test |=> o_test_cut)
		else $error("test length not chosen");
	chk_normal_pick: assert property (s_cut_norm |=> !o_test_cut)
		else $error("normal length not chosen");
	chk_test_hold: assert property ($changed(o_test_cut) |-> cut_q)
		else $error("test flag changed without cut");
	chk_vm_range: assert property (o_vm_units <= 14'h2710)
		else $error("virtual speed above full scale");
	chk_vm_moving: assert property (o_vm_moving == (o_vm_units != 14'h0))
		else $error("moving flag missing");
	chk_rd_data: assert property ((o_rdata != 0) |-> $past(i_rd))
		else $error("read data outside read slot");
endmodule
bind cut_length_virtual_master_setup cutlen_sva u_sva (.*);

// >>> test/line_encoder_model.sv
// quadrature model of the line encoder
`timescale 1ns/1ps
module line_encoder_model (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// motion request
	input wire logic i_run,
	input wire logic i_rev,
	// encoder lines
	output logic o_enc_a,
	output logic o_enc_b
);
	logic [1:0] ph_q;
	// one quadrature step per clock while running
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ph_q <= 2'h0;
		end else if (i_run) begin
			ph_q <= i_rev ? ph_q - 2'h1 : ph_q + 2'h1;
		end
	end
	// a leads b going forward
	assign o_enc_a = ph_q[0] ^ ph_q[1];
	assign o_enc_b = ph_q[1];
endmodule

// >>> test/cut_length_virtual_master_setup_tb.sv
// self-checking bench for the cut length and virtual master block
`timescale 1ns/1ps
`include "cutlen_defines.svh"
module cut_length_virtual_master_setup_tb;
	logic i_mclk;
	logic i_rst_n;
	logic [3:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic i_cut_pulse;
	logic i_test_sel;
	logic i_enc_a;
	logic i_enc_b;
	logic [39:0] o_cut_edges;
	logic o_test_cut;
	logic o_profile_busy;
	logic [31:0] o_line_edges;
	logic [13:0] o_vm_units;
	logic o_vm_moving;
	logic run;
	logic rev;
	int bad_count;
	int samples_checked;

	cut_length_virtual_master_setup #(.UNIT_CYCLES(2)) DUT (.*);
	line_encoder_model u_enc (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_run(run), .i_rev(rev), .o_enc_a(i_enc_a), .o_enc_b(i_enc_b));

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// -------------------------------------------------------------
	// shared tasks
	// -------------------------------------------------------------
	task cmp(string n, logic [39:0] e, logic [39:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %0h got %0h", n, e, g);
		end
	endtask
	task wr(logic [3:0] a, logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task rd(logic [3:0] a, logic [31:0] e);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 cmp("rdata", {8'h00, e}, {8'h00, o_rdata});
	endtask
	task cut(logic [39:0] e, logic t);
		@(posedge i_mclk);
		i_cut_pulse <= 1'b1;
		@(posedge i_mclk);
		i_cut_pulse <= 1'b0;
		#1 cmp("busy", 40'h1, {39'h0, o_profile_busy});
		repeat (60) begin
			@(posedge i_mclk);
			#1;
			if (o_profile_busy !== 1'b1) break;
		end
		cmp("busy_end", 40'h0, {39'h0, o_profile_busy});
		cmp("cut_edges", e, o_cut_edges);
		cmp("test_cut", {39'h0, t}, {39'h0, o_test_cut});
	endtask
	task enc(int n, logic r);
		@(posedge i_mclk);
		run <= 1'b1;
		rev <= r;
		repeat (n) @(posedge i_mclk);
		run <= 1'b0;
		repeat (2) @(posedge i_mclk);
	endtask

	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task t_reset;
		logic [31:0] rv [7];
		rv = '{32'h3E8, 32'h3E8, 32'h0, 32'h3E8, 32'h1000, 32'h0, 32'hF4240};
		for (int i = 0; i < 7; i++) rd(i[3:0], rv[i]);
		rd(4'hB, 32'h0);
		cmp("edges_rst", 40'h0, o_cut_edges);
	endtask
	task t_defer;
		wr(`ADR_CUT_LEN, 32'h1F4);
		rd(`ADR_CUT_LEN, 32'h1F4);
		cmp("no_apply", 40'h0, o_cut_edges);
		cut(40'h800, 1'b0);
		wr(`ADR_CUT_LEN, 32'hFA);
		repeat (50) @(posedge i_mclk);
		cmp("held", 40'h800, o_cut_edges);
		cut(40'h400, 1'b0);
		wr(`ADR_CUT_LEN, 32'h0);
		rd(`ADR_CUT_LEN, 32'h1);
		wr(`ADR_CUT_LEN, 32'h200000);
		rd(`ADR_CUT_LEN, 32'hF423F);
	endtask
	task t_test;
		wr(`ADR_TEST_LEN, 32'h7D0);
		@(posedge i_mclk);
		i_test_sel <= 1'b1;
		@(posedge i_mclk);
		i_test_sel <= 1'b0;
		repeat (3) @(posedge i_mclk);
		cut(40'h2000, 1'b1);
		rd(`ADR_CUT_EDGES, 32'h2000);
		rd(`ADR_STATUS, 32'h1);
		cut(40'h3E7FFB, 1'b0);
	endtask
	task t_scale;
		wr(`ADR_CIRC, 32'h30D40);
		rd(`ADR_CIRC, 32'h1869F);
		wr(`ADR_CIRC, 32'h3);
		wr(`ADR_PPR, 32'h7);
		for (int m = 0; m < 3; m++) begin
			wr(`ADR_CTRL, m);
			rd(`ADR_CTRL, m);
			cut(40'h239A93, 1'b0);
			enc(8, 1'b0);
			cmp("fwd", 40'h2 << m, {8'h0, o_line_edges});
			enc(8, 1'b1);
			cmp("rev", 40'h0, {8'h0, o_line_edges});
		end
	endtask
	task t_vm;
		wr(`ADR_SPEED_SP, 32'h7A120);
		repeat (60) @(posedge i_mclk);
		cmp("vm_half", 40'h1388, {26'h0, o_vm_units});
		cmp("moving", 40'h1, {39'h0, o_vm_moving});
		wr(`ADR_SPEED_SP, 32'h1312D00);
		rd(`ADR_SPEED_SP, 32'h98967F);
		repeat (60) @(posedge i_mclk);
		cmp("vm_clamp", 40'h2710, {26'h0, o_vm_units});
		rd(`ADR_VM_UNITS, 32'h2710);
		wr(`ADR_SPEED_SP, 32'h0);
		repeat (60) @(posedge i_mclk);
		cmp("vm_stop", 40'h0, {26'h0, o_vm_units});
		wr(`ADR_RAMP, 32'h1388);
		rd(`ADR_RAMP, 32'h3E7);
		wr(`ADR_RAMP, 32'h1);
		wr(`ADR_SPEED_SP, 32'h2710);
		repeat (60) @(posedge i_mclk);
		cmp("ramping", 40'h1, {39'h0, o_vm_units > 0 && o_vm_units < 100});
		repeat (300) @(posedge i_mclk);
		cmp("vm_ramped", 40'h64, {26'h0, o_vm_units});
		wr(`ADR_MAX_SPEED, 32'h1E8480);
		rd(`ADR_MAX_SPEED, 32'h1E8480);
		repeat (250) @(posedge i_mclk);
		cmp("vm_rescale", 40'h32, {26'h0, o_vm_units});
	endtask

	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#500000;
		bad_count++;
		conclude;
	end

	initial begin
		i_rst_n = 1'b0;
		i_addr = 4'h0;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_cut_pulse = 1'b0;
		i_test_sel = 1'b0;
		run = 1'b0;
		rev = 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset;
		t_defer;
		t_test;
		t_scale;
		t_vm;
		conclude;
	end
endmodule
